// ==== hw/pim_master_regs.sv ====
// Purpose: Master-mode priority interrupt controller with its APB register set.
// Assumes: Inputs synchronous to I_SYS_CLK; source pulses last one cycle.
// Notes: Sources 0 timer group, 1-2 DMA channels, 3-6 external inputs.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "pim_defs.svh"
`default_nettype none

module pim_master_regs
  import pim_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [2:0] I_TMR_REQ,
  input wire logic [1:0] I_DMA_REQ,
  input wire logic [3:0] I_EXT_INT,
  input wire logic I_INTA,
  input wire logic I_NMI,
  input wire logic I_RETURN_FROM_HANDLER_INSTR,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_INTR,
  output logic [4:0] O_VECTOR,
  output logic O_DMA_HALT
);

  localparam int NSRC = 7;

  // ========================================================================
  // Reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ========================================================================
  // State
  pim_ctl_s ctl [NSRC];
  logic [NSRC-1:0] in_service_bit;
  logic [1:0] dma_req;
  logic [2:0] per_timer_request_bits;
  logic dma_halt_flag;
  logic [2:0] level_mask_code;
  logic [3:0] ext_prev;
  logic [3:0] ext_edge;

  // ========================================================================
  // APB decode
  logic acc_first;
  logic acc_done;
  logic wr_done;
  logic [11:0] ofs;
  logic [15:0] wd;
  logic mapped;
  logic poll_rd;

  assign acc_first = I_PSEL & I_PENABLE & ~O_PREADY;
  assign acc_done = I_PSEL & I_PENABLE & O_PREADY;
  assign wr_done = acc_done & I_PWRITE;
  assign ofs = I_PADDR;
  assign wd = I_PWDATA[15:0];
  assign mapped = (ofs[1:0] == 2'h0) && (ofs <= `PIM_OFS_CTL_LAST);
  assign poll_rd = acc_first & ~I_PWRITE & (ofs == `PIM_OFS_POLL);

  function automatic int bitpos(input int s);
    int p;
    p = `PIM_BIT_TMR;
    if (s == 1) begin
      p = `PIM_BIT_DMA0;
    end else if (s == 2) begin
      p = `PIM_BIT_DMA1;
    end else if (s >= 3) begin
      p = `PIM_BIT_EXT0 + s - 3;
    end
    return p;
  endfunction

  // ========================================================================
  // Request vector and priority resolution
  logic [NSRC-1:0] req;
  logic [3:0] ext_used;
  logic [NSRC-1:0] elig;
  logic any_elig;
  pim_src_t best;
  logic [4:0] best_vt;
  logic [2:0] best_tmr;
  logic any_is;
  pim_src_t top_is;

  always_comb begin
    ext_used = 4'hF;
    if (ctl[3].cascade | ctl[3].special_nested_select) begin
      ext_used[2] = 1'b0;
    end
    if (ctl[4].cascade | ctl[4].special_nested_select) begin
      ext_used[3] = 1'b0;
    end
    req[0] = |per_timer_request_bits;
    req[1] = dma_req[0];
    req[2] = dma_req[1];
    for (int k = 0; k < 4; k++) begin
      // Level inputs follow the pin, edge inputs the captured transition.
      req[3+k] = ext_used[k] & (ctl[3+k].trigger_select ? I_EXT_INT[k] : ext_edge[k]);
    end
  end

  always_comb begin
    logic blocked;
    blocked = 1'b0;
    for (int s = 0; s < NSRC; s++) begin
      blocked = 1'b0;
      for (int t = 0; t < NSRC; t++) begin
        // An in-service source holds off its own and all equal or lower levels,
        // except that nested mode lets an external pin through its own bit.
        if (in_service_bit[t] && (ctl[t].priority_level_field <= ctl[s].priority_level_field)
            && !((t == s) && (s == 3 || s == 4) && ctl[s].special_nested_select)) begin
          blocked = 1'b1;
        end
      end
      elig[s] = req[s] & ~ctl[s].mask & ~blocked
                & (ctl[s].priority_level_field <= level_mask_code);
    end
  end

  always_comb begin
    any_elig = 1'b0;
    best = 3'h0;
    for (int s = 0; s < NSRC; s++) begin
      // Lower number wins; on a tie the earlier source keeps its place.
      if (elig[s] && (!any_elig ||
          ctl[s].priority_level_field < ctl[best].priority_level_field)) begin
        any_elig = 1'b1;
        best = pim_src_t'(s);
      end
    end
    any_is = 1'b0;
    top_is = 3'h0;
    for (int s = 0; s < NSRC; s++) begin
      if (in_service_bit[s] && (!any_is ||
          ctl[s].priority_level_field < ctl[top_is].priority_level_field)) begin
        any_is = 1'b1;
        top_is = pim_src_t'(s);
      end
    end
  end

  always_comb begin
    best_tmr = 3'h0;
    if (per_timer_request_bits[0]) begin
      best_tmr = 3'h1;
    end else if (per_timer_request_bits[1]) begin
      best_tmr = 3'h2;
    end else if (per_timer_request_bits[2]) begin
      best_tmr = 3'h4;
    end
    if (best == 3'h0) begin
      best_vt = best_tmr[2] ? `PIM_VT_TMR2 : (best_tmr[1] ? `PIM_VT_TMR1 : `PIM_VT_TMR0);
    end else if (best == 3'h1) begin
      best_vt = `PIM_VT_DMA0;
    end else if (best == 3'h2) begin
      best_vt = `PIM_VT_DMA1;
    end else begin
      best_vt = `PIM_VT_EXT0 + 5'(best - 3'h3);
    end
  end

  // ========================================================================
  // Acknowledge and end-of-service decoding
  logic ack;
  logic eoi_wr;
  pim_eoi_e eoi_kind;
  logic eoi_hit;
  pim_src_t eoi_src;

  assign ack = (I_INTA | poll_rd) & any_elig;
  assign eoi_wr = wr_done & (ofs == `PIM_OFS_EOI);
  assign eoi_kind = wd[`PIM_EOI_KIND] ? PIM_EOI_NONSPECIFIC : PIM_EOI_SPECIFIC;

  always_comb begin
    eoi_hit = 1'b1;
    eoi_src = 3'h0;
    if (eoi_kind == PIM_EOI_NONSPECIFIC) begin
      eoi_hit = any_is;
      eoi_src = top_is;
    end else if (wd[4:0] == `PIM_VT_TMR0 || wd[4:0] == `PIM_VT_TMR1
                 || wd[4:0] == `PIM_VT_TMR2) begin
      eoi_src = 3'h0;
    end else if (wd[4:0] == `PIM_VT_DMA0) begin
      eoi_src = 3'h1;
    end else if (wd[4:0] == `PIM_VT_DMA1) begin
      eoi_src = 3'h2;
    end else if (wd[4:0] >= `PIM_VT_EXT0 && wd[4:0] <= `PIM_VT_EXT0 + 5'h03) begin
      eoi_src = 3'h3 + 3'(wd[4:0] - `PIM_VT_EXT0);
    end else begin
      eoi_hit = 1'b0;
    end
  end

  // ========================================================================
  // In-service bits: write, then clear, then acknowledge; an acknowledge set wins
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      in_service_bit <= '0;
    end else begin
      logic [NSRC-1:0] next_is;
      next_is = in_service_bit;
      if (wr_done && ofs == `PIM_OFS_INSERV) begin
        for (int s = 0; s < NSRC; s++) begin
          next_is[s] = wd[bitpos(s)];
        end
      end
      if (eoi_wr && eoi_hit) begin
        next_is[eoi_src] = 1'b0;
      end
      if (ack) begin
        next_is[best] = 1'b1;
      end
      in_service_bit <= next_is;
    end
  end

  // ========================================================================
  // Internal requests: arrival wins over acknowledge and software clear
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      dma_req <= 2'h0;
    end else begin
      for (int d = 0; d < 2; d++) begin
        if (I_DMA_REQ[d]) begin
          dma_req[d] <= 1'b1;
        end else if (wr_done && ofs == `PIM_OFS_REQST) begin
          dma_req[d] <= wd[bitpos(d + 1)];
        end else if (ack && best == pim_src_t'(d + 1)) begin
          dma_req[d] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      per_timer_request_bits <= 3'h0;
    end else begin
      for (int t = 0; t < 3; t++) begin
        if (I_TMR_REQ[t]) begin
          per_timer_request_bits[t] <= 1'b1;
        end else if (wr_done && ofs == `PIM_OFS_STATUS) begin
          per_timer_request_bits[t] <= wd[t];
        end else if (ack && best == 3'h0 && best_tmr[t]) begin
          per_timer_request_bits[t] <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // External edge capture; a held-high line cannot re-arm until seen low
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev <= 4'hF;
      ext_edge <= 4'h0;
    end else begin
      ext_prev <= I_EXT_INT;
      for (int k = 0; k < 4; k++) begin
        if (I_EXT_INT[k] && !ext_prev[k]) begin
          ext_edge[k] <= 1'b1;
        end else if (ack && best == pim_src_t'(k + 3)) begin
          ext_edge[k] <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // DMA halt flag: a non-maskable event wins over the return
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      dma_halt_flag <= 1'b0;
    end else if (I_NMI) begin
      dma_halt_flag <= 1'b1;
    end else if (wr_done && ofs == `PIM_OFS_STATUS && wd[`PIM_STS_HALT]) begin
      dma_halt_flag <= 1'b1;
    end else if (I_RETURN_FROM_HANDLER_INSTR) begin
      dma_halt_flag <= 1'b0;
    end
  end

  // ========================================================================
  // Level mask and control words
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      level_mask_code <= `PIM_LVLMASK_RESET;
    end else if (wr_done && ofs == `PIM_OFS_PRIMSK) begin
      level_mask_code <= wd[2:0];
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < NSRC; s++) begin
        ctl[s] <= '{special_nested_select: 1'b0, cascade: 1'b0, trigger_select: 1'b0,
                    mask: 1'b1, priority_level_field: `PIM_PRI_RESET};
      end
    end else if (wr_done && ofs == `PIM_OFS_MASK) begin
      for (int s = 0; s < NSRC; s++) begin
        ctl[s].mask <= wd[bitpos(s)];
      end
    end else if (wr_done && ofs >= `PIM_OFS_CTL_BASE && ofs <= `PIM_OFS_CTL_LAST) begin
      for (int s = 0; s < NSRC; s++) begin
        if (ofs == `PIM_OFS_CTL_BASE + 12'(4 * s)) begin
          ctl[s].priority_level_field <= wd[2:0];
          ctl[s].mask <= wd[3];
          ctl[s].trigger_select <= (s >= 3) & wd[4];
          ctl[s].cascade <= (s == 3 || s == 4) & wd[5];
          ctl[s].special_nested_select <= (s == 3 || s == 4) & wd[6];
        end
      end
    end
  end

  // ========================================================================
  // Read data, captured in the first access cycle
  logic [15:0] rd_word;

  always_comb begin
    rd_word = 16'h0000;
    if (ofs == `PIM_OFS_POLL || ofs == `PIM_OFS_POLLST) begin
      rd_word[`PIM_POLL_REQ] = any_elig;
      rd_word[4:0] = any_elig ? best_vt : 5'h00;
    end else if (ofs == `PIM_OFS_MASK) begin
      for (int s = 0; s < NSRC; s++) begin
        rd_word[bitpos(s)] = ctl[s].mask;
      end
    end else if (ofs == `PIM_OFS_PRIMSK) begin
      rd_word[2:0] = level_mask_code;
    end else if (ofs == `PIM_OFS_INSERV) begin
      for (int s = 0; s < NSRC; s++) begin
        rd_word[bitpos(s)] = in_service_bit[s];
      end
    end else if (ofs == `PIM_OFS_REQST) begin
      for (int s = 0; s < NSRC; s++) begin
        rd_word[bitpos(s)] = req[s];
      end
    end else if (ofs == `PIM_OFS_STATUS) begin
      rd_word[`PIM_STS_HALT] = dma_halt_flag;
      rd_word[2:0] = per_timer_request_bits;
    end else if (ofs >= `PIM_OFS_CTL_BASE && ofs <= `PIM_OFS_CTL_LAST) begin
      for (int s = 0; s < NSRC; s++) begin
        if (ofs == `PIM_OFS_CTL_BASE + 12'(4 * s)) begin
          rd_word[6:0] = ctl[s];
        end
      end
    end
  end

  // ========================================================================
  // APB answer: one wait state, then pready with data and error
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
    end else begin
      O_PREADY <= acc_first;
      if (acc_first) begin
        O_PSLVERR <= ~mapped;
        O_PRDATA <= (I_PWRITE || !mapped) ? 32'h0000_0000 : {16'h0000, rd_word};
      end else begin
        O_PSLVERR <= 1'b0;
      end
    end
  end

  // ========================================================================
  // CPU request and status outputs
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_INTR <= 1'b0;
      O_VECTOR <= 5'h00;
      O_DMA_HALT <= 1'b0;
    end else begin
      O_INTR <= any_elig & ~ack;
      O_VECTOR <= any_elig ? best_vt : 5'h00;
      O_DMA_HALT <= dma_halt_flag;
    end
  end

endmodule

`default_nettype wire

// ==== hw/pim_defs.svh ====
// Purpose: Offsets, field positions, reset values and vector codes of the interrupt controller.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Included by the controller, the checker and the bench.
`ifndef PIM_DEFS_SVH
`define PIM_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define PIM_OFS_EOI 12'h000
`define PIM_OFS_POLL 12'h004
`define PIM_OFS_POLLST 12'h008
`define PIM_OFS_MASK 12'h00C
`define PIM_OFS_PRIMSK 12'h010
`define PIM_OFS_INSERV 12'h014
`define PIM_OFS_REQST 12'h018
`define PIM_OFS_STATUS 12'h01C
`define PIM_OFS_CTL_BASE 12'h020
`define PIM_OFS_CTL_LAST 12'h038

// ==========================================================================
// Bit positions in the in-service, request and mask words
`define PIM_BIT_TMR 0
`define PIM_BIT_DMA0 2
`define PIM_BIT_DMA1 3
`define PIM_BIT_EXT0 4

// ==========================================================================
// Status, end-of-service and poll word fields, and reset values
`define PIM_STS_HALT 15
`define PIM_EOI_KIND 15
`define PIM_POLL_REQ 15
`define PIM_LVLMASK_RESET 3'h7
`define PIM_PRI_RESET 3'h7

// ==========================================================================
// Vector types of the sources
`define PIM_VT_TMR0 5'h08
`define PIM_VT_TMR1 5'h12
`define PIM_VT_TMR2 5'h13
`define PIM_VT_DMA0 5'h0A
`define PIM_VT_DMA1 5'h0B
`define PIM_VT_EXT0 5'h0C

`endif

// ==== hw/pim_pkg.sv ====
// Purpose: Types shared by the interrupt controller files.
// Assumes: Nothing beyond the defines header.
// Notes: Control words travel as one packed struct.
package pim_pkg;

  // ========================================================================
  // Source control word, bit 0 upward: level, mask, trigger, cascade, nested
  typedef struct packed {
    logic special_nested_select;
    logic cascade;
    logic trigger_select;
    logic mask;
    logic [2:0] priority_level_field;
  } pim_ctl_s;

  typedef logic [2:0] pim_src_t;

  typedef enum logic {
    PIM_EOI_SPECIFIC,
    PIM_EOI_NONSPECIFIC
  } pim_eoi_e;

endpackage

// ==== dv/pim_master_regs_chk.sv ====
// Purpose: Port-level checks of the interrupt controller.
// Assumes: Read data is valid on the edge where PREADY is sampled high.
// Notes: Bound to every instance of the controller.
`timescale 1ns/1ps
`include "pim_defs.svh"
`default_nettype none

module pim_master_regs_chk
  import pim_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [2:0] I_TMR_REQ,
  input wire logic [1:0] I_DMA_REQ,
  input wire logic [3:0] I_EXT_INT,
  input wire logic I_INTA,
  input wire logic I_NMI,
  input wire logic I_RETURN_FROM_HANDLER_INSTR,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_INTR,
  input wire logic [4:0] O_VECTOR,
  input wire logic O_DMA_HALT
);
  // ========================================================================
  // Checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);
  logic rd_done;
  logic poll_rd;
  assign rd_done = I_PSEL && I_PENABLE && O_PREADY && !I_PWRITE;
  assign poll_rd = rd_done && (I_PADDR == `PIM_OFS_POLL || I_PADDR == `PIM_OFS_POLLST);
  function automatic logic vec_ok(input logic [4:0] v);
    return v inside {5'h08, 5'h12, 5'h13, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F};
  endfunction
  a_ack_drops_intr: assert property (I_INTA && O_INTR |=> !O_INTR)
    else $error("Request stayed up after acknowledge.");
  a_nmi_sets_halt: assert property (I_NMI |-> ##[1:2] O_DMA_HALT)
    else $error("Halt flag not set by NMI.");
  a_return_from_handler_instr_clears_halt: assert property (I_RETURN_FROM_HANDLER_INSTR && !I_NMI && !(I_PSEL && I_PWRITE)
    |-> ##[1:2] !O_DMA_HALT) else $error("Halt flag not cleared by return.");
  a_eoi_reads_zero: assert property (rd_done && I_PADDR == `PIM_OFS_EOI
    |-> O_PRDATA == 32'h0) else $error("End-of-service word readable.");
  a_poll_word_shape: assert property (poll_rd
    |-> O_PRDATA[31:16] == 16'h0 && O_PRDATA[14:5] == 10'h0) else $error("Poll word shape.");
  a_poll_vec_valid: assert property (poll_rd && O_PRDATA[15]
    |-> vec_ok(O_PRDATA[4:0])) else $error("Poll vector not a source vector.");
  a_lvlmask_bits: assert property (rd_done && I_PADDR == `PIM_OFS_PRIMSK
    |-> O_PRDATA[31:3] == 29'h0) else $error("Level mask has extra bits.");
  a_upper_half_zero: assert property (rd_done |-> O_PRDATA[31:16] == 16'h0)
    else $error("Upper half of read word not zero.");
  a_intr_vector_ok: assert property (O_INTR |-> vec_ok(O_VECTOR))
    else $error("Request with no source vector.");
  a_status_bits: assert property (rd_done && I_PADDR == `PIM_OFS_STATUS
    |-> O_PRDATA[14:3] == 12'h0) else $error("Status word shape.");
  cover property (I_INTA && O_INTR);
  cover property (rd_done && I_PADDR == `PIM_OFS_POLL && O_PRDATA[15]);
  cover property ($rose(O_DMA_HALT));
endmodule

bind pim_master_regs pim_master_regs_chk u_chk (.*);
`default_nettype wire

// ==== dv/pim_ext_src_model.sv ====
// Purpose: Model of the four external request sources.
// Assumes: Lines change just after the rising clock edge.
// Notes: A raised line falls only once the host has acknowledged it.
`timescale 1ns/1ps
`default_nettype none

module pim_ext_src_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_raise,
  input wire logic [3:0] i_drop,
  input wire logic [3:0] i_ack,
  output logic [3:0] o_line
);
  // ========================================================================
  // Source lines
  logic [3:0] acked;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_line <= 4'h0;
      acked <= 4'h0;
    end else begin
      // A drop request is ignored until the raised line has been acknowledged.
      o_line <= i_raise | (o_line & ~(i_drop & acked));
      acked <= ~i_raise & (acked | i_ack);
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Purpose: Self-checking bench of the interrupt controller.
// Assumes: APB answers after one wait state; inputs change on rising edges.
// Notes: External lines come from the source model.
`timescale 1ns/1ps
`include "pim_defs.svh"
`default_nettype none

module tb;
  import pim_pkg::*;
  // ========================================================================
  // Stimulus and design
  localparam logic [31:0] all_ones = 32'hFFFFFFFF;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [7:0] ev = 8'h00;
  logic [3:0] raise = 4'h0;
  logic [3:0] drop = 4'h0;
  logic [3:0] ack = 4'h0;
  logic [3:0] ext;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic serr;
  logic intr;
  logic halt;
  logic [4:0] vec;
  int err_count = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  pim_ext_src_model u_src (.i_clk(clk), .i_rst_n(rst_n), .i_raise(raise), .i_drop(drop),
    .i_ack(ack), .o_line(ext));
  pim_master_regs dut (.I_SYS_CLK(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd), .I_TMR_REQ(ev[2:0]),
    .I_DMA_REQ(ev[4:3]), .I_EXT_INT(ext), .I_INTA(ev[5]), .I_RETURN_FROM_HANDLER_INSTR(ev[6]), .I_NMI(ev[7]),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_INTR(intr),
    .O_VECTOR(vec), .O_DMA_HALT(halt));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 16) begin
      err_count++;
      summarize();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask
  task automatic pls(input logic [7:0] v, input logic [3:0] a);
    @(posedge clk);
    ev <= v;
    ack <= a;
    @(posedge clk);
    ev <= 8'h00;
    ack <= 4'h0;
  endtask
  task automatic src(input logic [3:0] r, input logic [3:0] d);
    @(posedge clk);
    raise <= r;
    drop <= d;
    @(posedge clk);
    raise <= 4'h0;
    drop <= 4'h0;
  endtask
  task automatic see(input logic v, input logic [4:0] vt);
    int n;
    repeat (2) @(posedge clk);
    for (n = 0; n < 8 && intr !== v; n++) @(posedge clk);
    chk({31'h0, intr}, {31'h0, v});
    if (v) chk({27'h0, vec}, {27'h0, vt});
  endtask
  task automatic t_reset();
    logic [31:0] r;
    rd(`PIM_OFS_PRIMSK, all_ones, 32'h7);
    rd(12'h020, all_ones, 32'hF);
    rd(`PIM_OFS_INSERV, all_ones, 32'h0);
    rd(`PIM_OFS_MASK, 32'hFD, 32'hFD);
    rd(`PIM_OFS_EOI, all_ones, 32'h0);
    apb(1'b0, 12'h040, 32'h0, r);
    chk({31'h0, serr}, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_timer();
    wr(12'h020, 32'h3);
    pls(8'h02, 4'h0);
    rd(`PIM_OFS_REQST, 32'h1, 32'h1);
    rd(`PIM_OFS_STATUS, 32'h7, 32'h2);
    see(1'b1, `PIM_VT_TMR1);
    pls(8'h20, 4'h0);
    rd(`PIM_OFS_INSERV, all_ones, 32'h1);
    rd(`PIM_OFS_REQST, all_ones, 32'h0);
    pls(8'h01, 4'h0);
    see(1'b0, 5'h00);
    wr(`PIM_OFS_EOI, 32'h8);
    rd(`PIM_OFS_INSERV, all_ones, 32'h0);
    see(1'b1, `PIM_VT_TMR0);
    rd(`PIM_OFS_POLL, all_ones, 32'h8008);
    rd(`PIM_OFS_INSERV, all_ones, 32'h1);
    wr(`PIM_OFS_EOI, 32'h8000);
    rd(`PIM_OFS_INSERV, all_ones, 32'h0);
    $display("timer test done");
  endtask
  task automatic t_dma();
    wr(12'h024, 32'h2);
    wr(12'h028, 32'h1);
    wr(`PIM_OFS_REQST, 32'hF5);
    rd(`PIM_OFS_REQST, all_ones, 32'h4);
    wr(`PIM_OFS_REQST, 32'hC);
    see(1'b1, `PIM_VT_DMA1);
    wr(`PIM_OFS_PRIMSK, 32'h0);
    see(1'b0, 5'h00);
    wr(`PIM_OFS_PRIMSK, 32'h1);
    see(1'b1, `PIM_VT_DMA1);
    wr(`PIM_OFS_PRIMSK, 32'h7);
    rd(`PIM_OFS_POLLST, all_ones, 32'h800B);
    rd(`PIM_OFS_INSERV, all_ones, 32'h0);
    pls(8'h20, 4'h0);
    see(1'b0, 5'h00);
    rd(`PIM_OFS_REQST, all_ones, 32'h4);
    wr(`PIM_OFS_EOI, 32'h8000);
    see(1'b1, `PIM_VT_DMA0);
    wr(12'h028, 32'h2);
    wr(`PIM_OFS_REQST, 32'hC);
    see(1'b1, `PIM_VT_DMA0);
    wr(`PIM_OFS_MASK, 32'hF7);
    rd(12'h024, all_ones, 32'hA);
    see(1'b1, `PIM_VT_DMA1);
    wr(`PIM_OFS_INSERV, 32'h8);
    rd(`PIM_OFS_INSERV, all_ones, 32'h8);
    see(1'b0, 5'h00);
    wr(`PIM_OFS_INSERV, 32'h0);
    wr(`PIM_OFS_REQST, 32'h0);
    see(1'b0, 5'h00);
    rd(`PIM_OFS_POLLST, 32'h8000, 32'h0);
    $display("dma test done");
  endtask
  task automatic t_halt();
    pls(8'h80, 4'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, halt}, 32'h1);
    rd(`PIM_OFS_STATUS, 32'h8000, 32'h8000);
    pls(8'h40, 4'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, halt}, 32'h0);
    wr(`PIM_OFS_STATUS, 32'h8004);
    rd(`PIM_OFS_STATUS, 32'h8007, 32'h8004);
    rd(`PIM_OFS_REQST, 32'h1, 32'h1);
    wr(`PIM_OFS_STATUS, 32'h0);
    rd(`PIM_OFS_STATUS, 32'h8007, 32'h8000);
    pls(8'h40, 4'h0);
    $display("halt test done");
  endtask
  task automatic t_ext();
    wr(12'h02C, 32'h0);
    src(4'h1, 4'h0);
    rd(`PIM_OFS_REQST, 32'hF0, 32'h10);
    see(1'b1, `PIM_VT_EXT0);
    pls(8'h20, 4'h1);
    rd(`PIM_OFS_INSERV, 32'hF0, 32'h10);
    wr(`PIM_OFS_EOI, 32'hC);
    rd(`PIM_OFS_INSERV, 32'hF0, 32'h0);
    rd(`PIM_OFS_REQST, 32'hF0, 32'h0);
    see(1'b0, 5'h00);
    src(4'h0, 4'h1);
    src(4'h1, 4'h0);
    see(1'b1, `PIM_VT_EXT0);
    wr(12'h02C, 32'h10);
    pls(8'h20, 4'h1);
    wr(`PIM_OFS_EOI, 32'h8000);
    see(1'b1, `PIM_VT_EXT0);
    src(4'h0, 4'h1);
    see(1'b0, 5'h00);
    wr(12'h02C, 32'h20);
    wr(12'h034, 32'h0);
    src(4'h4, 4'h0);
    see(1'b0, 5'h00);
    wr(12'h030, 32'h50);
    src(4'h2, 4'h0);
    pls(8'h20, 4'h2);
    see(1'b1, `PIM_VT_EXT0 + 5'h01);
    $display("external test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_timer();
    t_dma();
    t_halt();
    t_ext();
    summarize();
  end
endmodule
`default_nettype wire
